/* File: dll_ctrl_pkg.sv */
/*
 * Constants shared by the delay-loop controller: register offsets, field
 * positions, reset values and widths.
 * Assumes a register port with byte data and the offsets listed here.
 */
package dll_ctrl_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int COARSE_W = 6;
	localparam int FINE_W = 8;
	localparam int PHASE_W = 5;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [11:0] OFS_POWER = 12'h090;
	localparam logic [11:0] OFS_CONTROL = 12'h091;
	localparam logic [11:0] OFS_STATUS = 12'h092;
	localparam logic [11:0] OFS_GUARD = 12'h093;
	localparam logic [11:0] OFS_COARSE = 12'h094;
	localparam logic [11:0] OFS_FINE = 12'h095;
	localparam logic [11:0] OFS_READ_REQ = 12'h098;
	localparam logic [11:0] OFS_COARSE_RB = 12'h099;
	localparam logic [11:0] OFS_FINE_RB = 12'h09a;
	localparam logic [11:0] OFS_PHASE_RB = 12'h09b;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTL_ENABLE = 0;
	localparam int CTL_MODE_LO = 1;
	localparam int CTL_DIR_LO = 3;
	localparam int CTL_SEARCH_ERR = 6;
	localparam int CTL_TRACK_ERR = 7;
	localparam int ST_LOCKED = 0;
	localparam int ST_LOST = 1;
	localparam int ST_FAIL = 2;
	localparam int PWR_DOWN = 0;
	localparam int RD_REQ = 0;

	// ************************************************************
	// reset values and field widths
	// ************************************************************
	localparam logic [7:0] RST_POWER = 8'h1f;
	localparam logic [7:0] RST_CONTROL = 8'hf0;
	localparam logic [4:0] PWR_MASK = 5'h1f;
	localparam logic [3:0] RST_GUARD = 4'h0;
	localparam logic [5:0] RST_COARSE = 6'h00;
	localparam logic [7:0] RST_FINE = 8'h80;

	// search direction and controller mode encodings
	localparam logic [1:0] DIR_DOWN = 2'h0;
	localparam logic [1:0] DIR_UP = 2'h1;
	localparam logic [1:0] DIR_BOTH = 2'h2;
	localparam logic [1:0] MODE_SEARCH_TRACK = 2'h0;
	localparam logic [1:0] MODE_TRACK = 2'h1;
	localparam logic [1:0] MODE_SEARCH = 2'h2;
endpackage

/* File: dll_delay_stepper.sv */
/*
 * Up/down position counter for the combined coarse:fine delay code.
 * Assumes one clock, synchronous active-low reset, load taking priority.
 */
`timescale 1ns/1ns
`default_nettype none
module dll_delay_stepper #(
	parameter int WIDTH = 14
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_load,
	input wire logic [WIDTH-1:0] i_load_val,
	input wire logic i_up,
	input wire logic i_down,
	output logic [WIDTH-1:0] o_pos,
	output logic o_at_max,
	output logic o_at_min
);
	localparam logic [WIDTH-1:0] POS_MAX = '1;
	localparam logic [WIDTH-1:0] POS_MIN = '0;
	localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

	// a one-bit code leaves no room between the two ends
	if (WIDTH < 2) begin : g_width_check
		$error("stepper width below two bits");
	end

	// load wins; steps saturate at the ends instead of wrapping
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_pos <= POS_MIN;
		end else if (i_load) begin
			o_pos <= i_load_val;
		end else if (i_up && o_pos != POS_MAX) begin
			o_pos <= o_pos + ONE;
		end else if (i_down && o_pos != POS_MIN) begin
			o_pos <= o_pos - ONE;
		end
	end

	assign o_at_max = (o_pos == POS_MAX);
	assign o_at_min = (o_pos == POS_MIN);
endmodule
`default_nettype wire

/* File: dll_clock_delay_loop_ctrl.sv */
/*
 * Delay-locked loop controller for the converter sample clock: register
 * file, static setpoints, search/track sequencer, lock status, readback.
 * Assumes a byte-wide register port already decoded from the serial
 * control interface, and a phase comparator that pulses i_phase_valid
 * with an in-window / too-early verdict for the current delay code.
 */
`timescale 1ns/1ns
`default_nettype none
// Function
// RULE_01: enable low applies static coarse and fine setpoints
// RULE_02: enable high runs the closed feedback loop
// RULE_03: direction 00 searches downward only
// RULE_04: direction 01 searches upward only
// RULE_05: direction 10 (reset) searches up and down
// RULE_06: read-only fail flag bit 2, reset 0
// RULE_07: lost-lock flag bit 1, writable, reset 0
// RULE_08: read-only locked flag bit 0, reset 0
// RULE_09: six-bit coarse setpoint, reset zero, drives line
// RULE_10: eight-bit fine setpoint, reset 0x80, drives line
// RULE_11: mode 00 search+track, 01 track, 10 search
// RULE_12: failed search stops or retries per bit
// RULE_13: power-down bit set at reset holds loop
// RULE_14: read request rising edge captures readback values
module dll_clock_delay_loop_ctrl (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [11:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_phase_valid,
	input wire logic i_phase_in_window,
	input wire logic i_phase_early,
	input wire logic [4:0] i_phase_meas,
	output logic [7:0] o_reg_rdata,
	output logic [5:0] o_coarse_delay,
	output logic [7:0] o_fine_delay,
	output logic o_loop_power_down
);
	localparam int POS_W = dll_ctrl_pkg::COARSE_W + dll_ctrl_pkg::FINE_W;

	typedef enum logic [2:0] {
		S_IDLE, S_SEARCH_UP, S_SEARCH_DOWN, S_TRACK, S_HOLD, S_FAILED
	} loop_state_t;

	// ************************************************************
	// register file
	// ************************************************************
	logic [4:0] power_ctrl;
	logic [7:0] control;
	logic [3:0] guard_band;
	logic [5:0] coarse_setpoint;
	logic [7:0] fine_setpoint;
	logic read_req;
	logic read_req_prev;
	logic lock_achieved_flag;
	logic lost_flag;
	logic fail_flag;
	logic [5:0] coarse_rb;
	logic [7:0] fine_rb;
	logic [4:0] phase_rb;
	loop_state_t state;
	loop_state_t next_state;

	function automatic logic wr_hit(input logic [11:0] addr, input logic [11:0] ofs);
		wr_hit = (addr == ofs);
	endfunction

	wire logic loop_run = control[dll_ctrl_pkg::CTL_ENABLE]
		&& !power_ctrl[dll_ctrl_pkg::PWR_DOWN];
	wire logic [1:0] dir = control[dll_ctrl_pkg::CTL_DIR_LO +: 2];
	wire logic [1:0] mode = control[dll_ctrl_pkg::CTL_MODE_LO +: 2];
	wire logic search_retry = control[dll_ctrl_pkg::CTL_SEARCH_ERR];
	wire logic track_restart = control[dll_ctrl_pkg::CTL_TRACK_ERR];

	// plain read/write settings
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			power_ctrl <= dll_ctrl_pkg::PWR_MASK & dll_ctrl_pkg::RST_POWER[4:0]; // see RULE_13
			control <= dll_ctrl_pkg::RST_CONTROL; // see RULE_05
			guard_band <= dll_ctrl_pkg::RST_GUARD;
			coarse_setpoint <= dll_ctrl_pkg::RST_COARSE; // see RULE_09
			fine_setpoint <= dll_ctrl_pkg::RST_FINE; // see RULE_10
			read_req <= 1'b0;
		end else if (i_reg_wr) begin
			if (wr_hit(i_reg_addr, dll_ctrl_pkg::OFS_POWER))
				power_ctrl <= i_reg_wdata[4:0];
			if (wr_hit(i_reg_addr, dll_ctrl_pkg::OFS_CONTROL))
				control <= i_reg_wdata;
			if (wr_hit(i_reg_addr, dll_ctrl_pkg::OFS_GUARD))
				guard_band <= i_reg_wdata[3:0];
			if (wr_hit(i_reg_addr, dll_ctrl_pkg::OFS_COARSE))
				coarse_setpoint <= i_reg_wdata[5:0];
			if (wr_hit(i_reg_addr, dll_ctrl_pkg::OFS_FINE))
				fine_setpoint <= i_reg_wdata;
			if (wr_hit(i_reg_addr, dll_ctrl_pkg::OFS_READ_REQ))
				read_req <= i_reg_wdata[dll_ctrl_pkg::RD_REQ];
		end
	end

	// ************************************************************
	// delay code counter
	// ************************************************************
	logic [POS_W-1:0] pos;
	logic at_max;
	logic at_min;
	logic step_load;
	logic step_up;
	logic step_down;
	wire logic [POS_W-1:0] start_pos = {coarse_setpoint, fine_setpoint};
	wire logic meas = i_phase_valid && loop_run;
	wire logic search_mode = (mode != dll_ctrl_pkg::MODE_TRACK);

	dll_delay_stepper #(
		.WIDTH(POS_W)
	) u_stepper (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_load(step_load),
		.i_load_val(start_pos),
		.i_up(step_up),
		.i_down(step_down),
		.o_pos(pos),
		.o_at_max(at_max),
		.o_at_min(at_min)
	);

	// ************************************************************
	// search / track sequencer
	// ************************************************************
	logic found;
	logic search_fail;
	logic lose;
	always_comb begin
		next_state = state;
		step_load = 1'b0;
		step_up = 1'b0;
		step_down = 1'b0;
		found = 1'b0;
		search_fail = 1'b0;
		lose = 1'b0;
		case (state)
			S_IDLE: begin
				step_load = 1'b1; // search starts from the setpoints
				if (loop_run) begin // see RULE_02
					if (!search_mode)
						next_state = S_TRACK; // see RULE_11
					else if (dir == dll_ctrl_pkg::DIR_DOWN)
						next_state = S_SEARCH_DOWN; // see RULE_03
					else
						next_state = S_SEARCH_UP; // see RULE_04
				end
			end
			S_SEARCH_UP: if (meas) begin
				if (i_phase_in_window) begin
					found = 1'b1;
				end else if (!at_max) begin
					step_up = 1'b1;
				end else if (dir == dll_ctrl_pkg::DIR_BOTH) begin
					step_load = 1'b1; // upper half exhausted, try below start
					next_state = S_SEARCH_DOWN; // see RULE_05
				end else begin
					search_fail = 1'b1; // see RULE_04
				end
			end
			S_SEARCH_DOWN: if (meas) begin
				if (i_phase_in_window)
					found = 1'b1;
				else if (!at_min)
					step_down = 1'b1; // see RULE_03
				else
					search_fail = 1'b1;
			end
			S_TRACK: if (meas && !i_phase_in_window) begin
				// follow the comparator one code at a time
				step_up = i_phase_early;
				step_down = !i_phase_early;
				lose = lock_achieved_flag;
				if (lose && track_restart && search_mode) begin
					step_load = 1'b1;
					step_up = 1'b0;
					step_down = 1'b0;
					next_state = S_IDLE;
				end
			end
			S_HOLD, S_FAILED: ;
			default: next_state = S_IDLE;
		endcase
		if (found)
			next_state = (mode == dll_ctrl_pkg::MODE_SEARCH) ? S_HOLD : S_TRACK; // see RULE_11
		if (search_fail) begin
			step_load = 1'b1;
			next_state = search_retry ? S_IDLE : S_FAILED; // see RULE_12
		end
		if (!loop_run)
			next_state = S_IDLE; // see RULE_13
	end

	// state register
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			state <= S_IDLE;
		else
			state <= next_state;
	end

	// ************************************************************
	// status flags: hardware set wins over a software write
	// ************************************************************
	wire logic status_wr = i_reg_wr && wr_hit(i_reg_addr, dll_ctrl_pkg::OFS_STATUS);
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			lock_achieved_flag <= 1'b0; // see RULE_08
			lost_flag <= 1'b0;
			fail_flag <= 1'b0;
		end else begin
			if (!loop_run || lose || search_fail)
				lock_achieved_flag <= 1'b0;
			else if (found || (state == S_TRACK && meas && i_phase_in_window))
				lock_achieved_flag <= 1'b1; // see RULE_08
			if (lose)
				lost_flag <= 1'b1; // see RULE_07
			else if (status_wr)
				lost_flag <= i_reg_wdata[dll_ctrl_pkg::ST_LOST];
			// fail stays until the next search finds the window
			if (search_fail)
				fail_flag <= 1'b1; // see RULE_06
			else if (found)
				fail_flag <= 1'b0;
		end
	end

	// ************************************************************
	// delay line drive and power-down output
	// ************************************************************
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_coarse_delay <= dll_ctrl_pkg::RST_COARSE;
			o_fine_delay <= dll_ctrl_pkg::RST_FINE;
			o_loop_power_down <= 1'b1;
		end else begin
			if (loop_run) begin
				o_coarse_delay <= pos[POS_W-1 -: dll_ctrl_pkg::COARSE_W]; // see RULE_02
				o_fine_delay <= pos[dll_ctrl_pkg::FINE_W-1:0];
			end else begin
				o_coarse_delay <= coarse_setpoint; // see RULE_01
				o_fine_delay <= fine_setpoint; // see RULE_10
			end
			o_loop_power_down <= power_ctrl[dll_ctrl_pkg::PWR_DOWN]; // see RULE_13
		end
	end

	// ************************************************************
	// readback capture on request edge
	// ************************************************************
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			read_req_prev <= 1'b0;
			coarse_rb <= '0;
			fine_rb <= '0;
			phase_rb <= '0;
		end else begin
			read_req_prev <= read_req;
			if (read_req && !read_req_prev) begin
				coarse_rb <= o_coarse_delay; // see RULE_14
				fine_rb <= o_fine_delay;
				phase_rb <= i_phase_meas;
			end
		end
	end

	// registered read data; unmapped offsets read zero
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 8'h00;
		end else begin
			case (i_reg_addr)
				dll_ctrl_pkg::OFS_POWER: o_reg_rdata <= {3'h0, power_ctrl};
				dll_ctrl_pkg::OFS_CONTROL: o_reg_rdata <= control;
				dll_ctrl_pkg::OFS_STATUS: o_reg_rdata <= {5'h00, fail_flag, lost_flag,
					lock_achieved_flag};
				dll_ctrl_pkg::OFS_GUARD: o_reg_rdata <= {4'h0, guard_band};
				dll_ctrl_pkg::OFS_COARSE: o_reg_rdata <= {2'h0, coarse_setpoint};
				dll_ctrl_pkg::OFS_FINE: o_reg_rdata <= fine_setpoint;
				dll_ctrl_pkg::OFS_READ_REQ: o_reg_rdata <= {7'h00, read_req};
				dll_ctrl_pkg::OFS_COARSE_RB: o_reg_rdata <= {2'h0, coarse_rb};
				dll_ctrl_pkg::OFS_FINE_RB: o_reg_rdata <= fine_rb;
				dll_ctrl_pkg::OFS_PHASE_RB: o_reg_rdata <= {3'h0, phase_rb};
				default: o_reg_rdata <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: dll_ctrl_sva.sv */
/* assertions on the delay-loop controller ports
   assumes a bind onto dll_clock_delay_loop_ctrl */
`timescale 1ns/1ns
`default_nettype none
module dll_ctrl_sva (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [11:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic [5:0] o_coarse_delay,
	input wire logic [7:0] o_fine_delay,
	input wire logic o_loop_power_down
);
	// ****************
	// software view
	// ****************
	logic en_m;
	logic pd_m;
	logic [1:0] qc;
	wire logic st = !en_m || pd_m;
	// mirrored from writes, so no internal signal is needed
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			en_m <= 1'b0;
			pd_m <= 1'b1;
		end else if (i_reg_wr && i_reg_addr == 12'h091) begin
			en_m <= i_reg_wdata[0];
		end else if (i_reg_wr && i_reg_addr == 12'h090) begin
			pd_m <= i_reg_wdata[0];
		end
	end
	// quiet cycles with the loop stopped, saturating at 3
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n || i_reg_wr || !st) begin
			qc <= 2'd0;
		end else if (qc != 2'd3) begin
			qc <= qc + 2'd1;
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	sequence s_wr(a);
		i_reg_wr && i_reg_addr == a && st;
	endsequence
	a_reset_out: assert property (disable iff (1'b0) !i_rst_n |=>
		o_coarse_delay == 6'h00 && o_fine_delay == 8'h80 && o_loop_power_down)
		else $error("outputs not at reset values");
	a_coarse_static: assert property (s_wr(12'h094) |->
		##2 o_coarse_delay == $past(i_reg_wdata[5:0], 2))
		else $error("coarse setpoint not applied");
	a_fine_static: assert property (s_wr(12'h095) |->
		##2 o_fine_delay == $past(i_reg_wdata, 2))
		else $error("fine setpoint not applied");
	a_pd_follow: assert property (i_reg_wr && i_reg_addr == 12'h090 |->
		##2 o_loop_power_down == $past(i_reg_wdata[0], 2))
		else $error("power-down output wrong");
	a_static_hold: assert property (qc == 2'd3 |->
		$stable(o_coarse_delay) && $stable(o_fine_delay))
		else $error("delay moved while stopped");
	a_lock_off: assert property (qc == 2'd3 && !en_m && i_reg_addr == 12'h092 |=>
		!o_reg_rdata[0])
		else $error("locked flag set while disabled");
	a_status_rsvd: assert property (i_reg_addr == 12'h092 |=>
		o_reg_rdata[7:3] == 5'h00)
		else $error("status upper bits not zero");
	a_unmapped_zero: assert property (i_reg_addr > 12'h09b |=> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind dll_clock_delay_loop_ctrl dll_ctrl_sva i_sva (
	.i_mclk(i_mclk),
	.i_rst_n(i_rst_n),
	.i_reg_addr(i_reg_addr),
	.i_reg_wr(i_reg_wr),
	.i_reg_wdata(i_reg_wdata),
	.o_reg_rdata(o_reg_rdata),
	.o_coarse_delay(o_coarse_delay),
	.o_fine_delay(o_fine_delay),
	.o_loop_power_down(o_loop_power_down)
);
`default_nettype wire

/* File: tb.sv */
/* self-checking bench for the delay-loop controller
   assumes package, design and checker compiled before it */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin \
	n_tests++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("Error %s expected %h seen %h", n, e, g); \
	end \
end
module tb;
	// ****************
	// stimulus
	// ****************
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [11:0] i_reg_addr = 12'h000;
	logic i_reg_wr = 1'b0;
	logic [7:0] i_reg_wdata = 8'h00;
	logic i_phase_valid = 1'b0;
	logic i_phase_in_window = 1'b0;
	logic i_phase_early = 1'b0;
	logic [4:0] i_phase_meas = 5'h00;
	logic [7:0] o_reg_rdata;
	logic [5:0] o_coarse_delay;
	logic [7:0] o_fine_delay;
	logic o_loop_power_down;
	int failures = 0;
	int n_tests = 0;
	integer pos;
	logic [31:0] seed = 32'h392d47e4;
	// reset table, {offset, value}; 0x0a0 is unmapped
	logic [19:0] tbl [$] = {20'h0901f, 20'h091f0, 20'h09200, 20'h09300, 20'h09400,
		20'h09580, 20'h09800, 20'h09900, 20'h09a00, 20'h09b00, 20'h0a000};
	dll_clock_delay_loop_ctrl i_dut (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_reg_addr(i_reg_addr),
		.i_reg_wr(i_reg_wr),
		.i_reg_wdata(i_reg_wdata),
		.i_phase_valid(i_phase_valid),
		.i_phase_in_window(i_phase_in_window),
		.i_phase_early(i_phase_early),
		.i_phase_meas(i_phase_meas),
		.o_reg_rdata(o_reg_rdata),
		.o_coarse_delay(o_coarse_delay),
		.o_fine_delay(o_fine_delay),
		.o_loop_power_down(o_loop_power_down)
	);
	// 50 ns clock
	initial begin
		forever #25 i_mclk = ~i_mclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic w(input logic [11:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_mclk);
		i_reg_wr <= 1'b0;
	endtask
	// read data trails the address, so wait two edges
	task automatic r(input logic [11:0] a, input logic [7:0] e);
		@(posedge i_mclk);
		i_reg_addr <= a;
		repeat (2) @(posedge i_mclk);
		#1;
		`CHK("rdata", e, o_reg_rdata)
	endtask
	// one verdict, then room for counter and output flop
	task automatic p(input logic inw, input logic early);
		@(posedge i_mclk);
		i_phase_valid <= 1'b1;
		i_phase_in_window <= inw;
		i_phase_early <= early;
		@(posedge i_mclk);
		i_phase_valid <= 1'b0;
		repeat (3) @(posedge i_mclk);
		#1;
	endtask
	task automatic q;
		`CHK("pos", 14'(pos), {o_coarse_delay, o_fine_delay})
	endtask
	task automatic run(input logic [7:0] c);
		w(12'h091, 8'he0);
		w(12'h091, c);
		repeat (3) @(posedge i_mclk);
	endtask
	task automatic report_and_stop;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// guards against a hang; the run takes well under 2000 cycles
	initial begin
		repeat (5000) @(posedge i_mclk);
		failures++;
		report_and_stop();
	end
	initial begin
		repeat (3) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		foreach (tbl[k]) r(tbl[k][19:8], tbl[k][7:0]);
		$display("test reset done");
		seed = lfsr(seed);
		w(12'h090, 8'h1e);
		w(12'h094, {2'h0, seed[5:0]});
		w(12'h095, seed[15:8]);
		w(12'h092, 8'h05);
		w(12'h099, 8'hff);
		#1;
		`CHK("coarse", seed[5:0], o_coarse_delay)
		`CHK("fine", seed[15:8], o_fine_delay)
		`CHK("pd", 1'b0, o_loop_power_down)
		r(12'h092, 8'h00);
		r(12'h099, 8'h00);
		$display("test static done");
		w(12'h094, 8'h10);
		w(12'h095, 8'h40);
		// down, up, then both, which starts upward
		for (int d = 0; d < 3; d++) begin
			run({3'h7, 2'(d), 3'h1});
			pos = 'h1040;
			repeat (3) begin
				p(1'b0, 1'b0);
				pos = pos + ((d == 0) ? -1 : 1);
				q();
			end
		end
		p(1'b1, 1'b0);
		r(12'h092, 8'h01);
		p(1'b0, 1'b1);
		r(12'h092, 8'h02);
		w(12'h092, 8'h00);
		r(12'h092, 8'h00);
		$display("test search done");
		// track only follows the early verdict both ways
		run(8'h03);
		pos = 'h1040;
		p(1'b0, 1'b1);
		pos = pos + 1;
		q();
		p(1'b0, 1'b0);
		pos = pos - 1;
		q();
		// search only holds after lock
		run(8'h0d);
		p(1'b1, 1'b0);
		p(1'b0, 1'b1);
		q();
		$display("test mode done");
		// at the top end an upward search fails: stop or retry
		w(12'h094, 8'h3f);
		w(12'h095, 8'hfe);
		for (int se = 0; se < 2; se++) begin
			run({1'b0, 1'(se), 6'h0d});
			p(1'b0, 1'b0);
			p(1'b0, 1'b0);
			// a failed search reloads the start code, stop or retry alike
			pos = 'h3ffe;
			q();
			// only a retried search takes the next verdict
			p(1'b0, 1'b0);
			pos = (se == 1) ? 'h3fff : 'h3ffe;
			q();
			r(12'h092, 8'h04);
		end
		// both ways turns downward at the top end
		run(8'h35);
		repeat (3) p(1'b0, 1'b0);
		// up to the top, reload, then one step below the start
		pos = 'h3ffd;
		q();
		$display("test fail done");
		w(12'h091, 8'he0);
		i_phase_meas <= seed[20:16];
		repeat (4) @(posedge i_mclk);
		w(12'h098, 8'h01);
		r(12'h099, 8'h3f);
		r(12'h09a, 8'hfe);
		r(12'h09b, {3'h0, seed[20:16]});
		$display("test readback done");
		// a reset in mid-run must clear flags and readback again
		@(posedge i_mclk);
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		r(12'h092, 8'h00);
		r(12'h099, 8'h00);
		`CHK("pd", 1'b1, o_loop_power_down)
		$display("test second reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
